// [core/cdv_pkg.sv]
// Package for the pair-C channel divider and Vco_divide_ratio control block.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
`default_nettype none
package cdv_pkg;
  // Register indices as printed; byte address is four times the index.
  localparam logic [9:0] IDX_TIMING  = 10'h196;
  localparam logic [9:0] IDX_CONTROL = 10'h197;
  localparam logic [9:0] IDX_ROUTE   = 10'h198;
  localparam logic [9:0] IDX_VCO_DIV = 10'h1e0;
  localparam logic [9:0] IDX_CLK_IN  = 10'h1e1;
  localparam logic [9:0] IDX_UPDATE  = 10'h232;
  localparam logic [9:0] IDX_STATUS  = 10'h233;
  // Field positions.
  localparam int LOW_MSB = 7;
  localparam int LOW_LSB = 4;
  localparam int HIGH_MSB = 3;
  localparam int BYPASS_BIT = 7;
  localparam int NOSYNC_BIT = 6;
  localparam int FORCE_BIT = 5;
  localparam int START_BIT = 4;
  localparam int PHASE_MSB = 3;
  localparam int DIRECT_BIT = 1;
  localparam int DCC_BIT = 0;
  localparam int CLKPD_BIT = 4;
  localparam int IFPD_BIT = 3;
  localparam int BOTHPD_BIT = 2;
  localparam int SRCSEL_BIT = 1;
  localparam int VBYP_BIT = 0;
  localparam int UPDATE_BIT = 0;
  // Values after reset.
  localparam logic [7:0] RST_TIMING  = 8'h00;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_ROUTE   = 8'h00;
  localparam logic [7:0] RST_VCO_DIV = 8'h02;
  localparam logic [7:0] RST_CLK_IN  = 8'h00;
  // Vco_divide_ratio codes and source/bypass pairs.
  localparam logic [2:0] VCO_CODE_MAX = 3'h4;
  localparam logic [2:0] VCO_RATIO_BASE = 3'h2;
  localparam logic [1:0] ROUTE_VCO = 2'h2;
  localparam logic [1:0] ROUTE_EXT = 2'h0;

  // Active register image moved as one unit.
  typedef struct packed {
    logic [7:0] timing;
    logic [7:0] control;
    logic [7:0] route;
    logic [7:0] vco_div;
    logic [7:0] clk_in;
  } cdv_regs_t;

  localparam cdv_regs_t RST_REGS = '{RST_TIMING, RST_CONTROL, RST_ROUTE,
                                     RST_VCO_DIV, RST_CLK_IN};

  typedef enum logic [1:0] {CDV_HOLD, CDV_DELAY, CDV_RUN} cdv_state_t;
endpackage
`default_nettype wire

// [core/cdv_top.sv]
// Pair-C channel divider, Vco_divide_ratio and clock input controls with a Wishbone slave.
// Assumes the VCO and external clock arrive as slow pins sampled on clock, and that
// the chip-level sync pin is active low.
// Limitation: source pins are sampled, so each of their levels must last at least
// one clock cycle for every rising edge to be counted.
//
// Functional notes
// - Output stays low for low-count plus one input cycles; field resets zero.
// - Output stays high for high-count plus one input cycles; field resets zero.
// - Bypass bit powers divider down and passes its input straight through.
// - Sync-ignore clear obeys chip-level sync; set lets the divider run through it.
// - Force bit gives static high or low while sync is asserted with sync-ignore set.
// - Start-level bit picks whether the divided clock begins low or high.
// - Four-bit phase offset delays the divider output start after sync.
// - Direct route takes VCO at 10b, external clock at 00b, divider at 01b.
// - Duty-cycle correction on when its disable bit is zero.
// - Vco_divide_ratio codes 0 to 4 divide by 2 to 6; others static.
// - Clock input power-down stops input buffer, Vco_divide_ratio and clock tree.
// - Interface power-down stops the link from VCO to distribution.
// - Combined power-down stops both VCO and external clock input.
// - Source select feeds Vco_divide_ratio from external clock or VCO.
// - Vco_divide_ratio bypass, refused while the VCO is the source.
// - Writes go to buffers; self-clearing update copies all to active.
//
// Design decision made here: the Wishbone register port.
`default_nettype none
module cdv_top (
  // Clock and reset.
  input  wire logic        clock,
  input  wire logic        reset,
  // Wishbone slave.
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [11:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Clock and sync pins.
  input  wire logic        vco_clk_pin,
  input  wire logic        ext_clk_pin,
  input  wire logic        sync_n_pin,
  // Output pair and status.
  output logic             pair_c_output_a,
  output logic             pair_c_output_b,
  output logic             duty_correct_on,
  output logic             divider_powered
);

  //////////////////////////////////////////////////////////////////////////////
  // Register file.
  cdv_pkg::cdv_regs_t buf_regs;
  cdv_pkg::cdv_regs_t act_regs;
  logic [31:0]        rd_data;
  logic [7:0]         status_byte;
  logic [9:0]         idx;
  logic               req;
  logic               wr_lane;
  logic               update_hit;

  // Request decode; only byte lane 0 holds the 8-bit registers.
  // A request is taken while ack is low; a write lands one cycle later, at the
  // edge where the master samples ack high, so an aborted cycle writes nothing.
  // The ack term in req keeps a held strobe from being taken twice.
  assign idx        = wb_adr_i[11:2];
  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr_lane    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
  assign update_hit = wr_lane && idx == cdv_pkg::IDX_UPDATE
                      && wb_dat_i[cdv_pkg::UPDATE_BIT];

  // Ack comes one cycle after the request is seen and drops the cycle after.
  // Read data is captured with ack and holds until the next request is taken.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= rd_data;
      end
    end
  end

  // Buffer registers take writes; unmapped indices are acked and ignored.
  // Only the implemented bits are stored; the rest read back as zero.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      buf_regs <= cdv_pkg::RST_REGS;
    end else if (wr_lane) begin
      if (idx == cdv_pkg::IDX_TIMING)  buf_regs.timing  <= wb_dat_i[7:0];
      if (idx == cdv_pkg::IDX_CONTROL) buf_regs.control <= wb_dat_i[7:0];
      if (idx == cdv_pkg::IDX_ROUTE)   buf_regs.route   <= {6'h00, wb_dat_i[1:0]};
      if (idx == cdv_pkg::IDX_VCO_DIV) buf_regs.vco_div <= {5'h00, wb_dat_i[2:0]};
      if (idx == cdv_pkg::IDX_CLK_IN)  buf_regs.clk_in  <= {3'h0, wb_dat_i[4:0]};
    end
  end

  // The update bit is never stored, so it reads back zero and clears itself.
  // Copying the whole image at once means a half-written setting never reaches
  // the divider; the price is that every change needs an update write.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      act_regs <= cdv_pkg::RST_REGS;
    end else if (update_hit) begin
      act_regs <= buf_regs;
    end
  end

  // Read mux: buffers read back as written, status shows live state.
  // Reads show buffers, not active values, so software sees what it wrote even
  // before the update.
  assign rd_data =
      (idx == cdv_pkg::IDX_TIMING)  ? {24'h00_0000, buf_regs.timing}  :
      (idx == cdv_pkg::IDX_CONTROL) ? {24'h00_0000, buf_regs.control} :
      (idx == cdv_pkg::IDX_ROUTE)   ? {24'h00_0000, buf_regs.route}   :
      (idx == cdv_pkg::IDX_VCO_DIV) ? {24'h00_0000, buf_regs.vco_div} :
      (idx == cdv_pkg::IDX_CLK_IN)  ? {24'h00_0000, buf_regs.clk_in}  :
      (idx == cdv_pkg::IDX_STATUS)  ? {24'h00_0000, status_byte}      :
      32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////
  // Active fields.
  // Every field below comes from the active image only; buffer writes alone never
  // disturb a running divider.
  // The select and bypass bits together form the pair that direct routing decodes.
  logic [3:0] low_cnt;
  logic [3:0] high_cnt;
  logic       ch_bypass;
  logic       nosync;
  logic       force_high;
  logic       start_high;
  logic [3:0] phase_ofs;
  logic       direct;
  logic [2:0] vco_code;
  logic       clk_pd;
  logic       if_pd;
  logic       both_pd;
  logic       src_vco;
  logic       vco_bypass;
  logic [1:0] src_pair;

  assign low_cnt    = act_regs.timing[cdv_pkg::LOW_MSB:cdv_pkg::LOW_LSB];
  assign high_cnt   = act_regs.timing[cdv_pkg::HIGH_MSB:0];
  assign ch_bypass  = act_regs.control[cdv_pkg::BYPASS_BIT];
  assign nosync     = act_regs.control[cdv_pkg::NOSYNC_BIT];
  assign force_high = act_regs.control[cdv_pkg::FORCE_BIT];
  assign start_high = act_regs.control[cdv_pkg::START_BIT];
  assign phase_ofs  = act_regs.control[cdv_pkg::PHASE_MSB:0];
  assign direct     = act_regs.route[cdv_pkg::DIRECT_BIT];
  assign vco_code   = act_regs.vco_div[2:0];
  assign clk_pd     = act_regs.clk_in[cdv_pkg::CLKPD_BIT];
  assign if_pd      = act_regs.clk_in[cdv_pkg::IFPD_BIT];
  assign both_pd    = act_regs.clk_in[cdv_pkg::BOTHPD_BIT];
  assign src_vco    = act_regs.clk_in[cdv_pkg::SRCSEL_BIT];
  assign vco_bypass = act_regs.clk_in[cdv_pkg::VBYP_BIT];
  assign src_pair   = {src_vco, vco_bypass};

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and input edge detection.
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic [2:0] pin_last;
  logic       vco_lvl;
  logic       ext_lvl;
  logic       sync_asserted;
  logic       vco_tick;
  logic       ext_tick;

  // Two flops per pin; the first stage is never read by logic.
  // The chain resets high so that a low sync pin reads as asserted only after two
  // clean samples, and a source pin held high gives no false edge after reset.
  // The third stage only remembers the last level for edge detection.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      sync_a   <= 3'h7;
      sync_b   <= 3'h7;
      pin_last <= 3'h7;
    end else begin
      sync_a   <= {sync_n_pin, ext_clk_pin, vco_clk_pin};
      sync_b   <= sync_a;
      pin_last <= sync_b;
    end
  end

  // Power-downs gate the sources before anything counts them.
  // Gating the level and not the last sample means a source that powers up while
  // high is counted only when it next rises.
  assign vco_lvl       = sync_b[0] && !if_pd && !both_pd && !clk_pd;
  assign ext_lvl       = sync_b[1] && !both_pd && !clk_pd;
  assign vco_tick      = vco_lvl && !pin_last[0];
  assign ext_tick      = ext_lvl && !pin_last[1];
  assign sync_asserted = !sync_b[2];

  //////////////////////////////////////////////////////////////////////////////
  // Vco_divide_ratio.
  // The ratio counter is three bits wide, enough for the largest ratio of six.
  // Static codes and the clock input power-down park it at zero so that the
  // next legal code always starts from a known phase.
  logic       vdiv_in_lvl;
  logic       vdiv_in_tick;
  logic       vdiv_static;
  logic       vdiv_skip;
  logic [2:0] vdiv_ratio;
  logic [2:0] vdiv_cnt;
  logic       vdiv_wrap;
  logic       vdiv_lvl;
  logic       vdiv_tick;
  logic       chan_in_lvl;
  logic       chan_in_tick;

  assign vdiv_in_lvl  = src_vco ? vco_lvl : ext_lvl;
  assign vdiv_in_tick = src_vco ? vco_tick : ext_tick;
  // Bypass with the VCO as source is not a legal pair, so it is ignored then.
  assign vdiv_skip    = vco_bypass && !src_vco;
  assign vdiv_static  = vco_code > cdv_pkg::VCO_CODE_MAX;
  assign vdiv_ratio   = vco_code + cdv_pkg::VCO_RATIO_BASE;
  assign vdiv_wrap    = vdiv_cnt >= vdiv_ratio - 3'h1;
  assign vdiv_tick    = vdiv_in_tick && vdiv_wrap && !vdiv_static && !clk_pd;
  // Divided level is high for the first half, rounded up, of each period.
  assign vdiv_lvl     = !vdiv_static && !clk_pd && vdiv_cnt < ((vdiv_ratio + 3'h1) >> 1);
  assign chan_in_lvl  = vdiv_skip ? vdiv_in_lvl : vdiv_lvl;
  assign chan_in_tick = vdiv_skip ? vdiv_in_tick : vdiv_tick;

  // Count input edges; static codes and power-down park the counter.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      vdiv_cnt <= 3'h0;
    end else if (vdiv_static || clk_pd) begin
      vdiv_cnt <= 3'h0;
    end else if (vdiv_in_tick) begin
      vdiv_cnt <= vdiv_wrap ? 3'h0 : vdiv_cnt + 3'h1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Channel divider.
  // HOLD waits out bypass and sync, DELAY counts the phase offset in input
  // edges, RUN toggles the level each time the count reaches the half limit.
  // A field value of n gives n plus one input edges per half period.
  cdv_pkg::cdv_state_t state;
  cdv_pkg::cdv_state_t next_state;
  logic [3:0]          cnt;
  logic [3:0]          next_cnt;
  logic                lvl;
  logic                next_lvl;
  logic                sync_hold;
  logic [3:0]          half_limit;

  // Sync only holds the divider when the channel obeys it.
  assign sync_hold  = sync_asserted && !nosync;
  assign half_limit = lvl ? high_cnt : low_cnt;

  // Next-state logic; bypass and sync take priority over every state.
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_lvl   = lvl;
    if (ch_bypass || sync_hold) begin
      next_state = cdv_pkg::CDV_HOLD;
      next_cnt   = 4'h0;
      next_lvl   = start_high;
    end else begin
      unique case (state)
        cdv_pkg::CDV_HOLD: begin
          next_state = cdv_pkg::CDV_DELAY;
          next_cnt   = phase_ofs;
          next_lvl   = start_high;
        end
        cdv_pkg::CDV_DELAY: begin
          if (cnt == 4'h0) begin
            next_state = cdv_pkg::CDV_RUN;
          end else if (chan_in_tick) begin
            next_cnt = cnt - 4'h1;
          end
        end
        cdv_pkg::CDV_RUN: begin
          if (chan_in_tick) begin
            if (cnt >= half_limit) begin
              next_cnt = 4'h0;
              next_lvl = !lvl;
            end else begin
              next_cnt = cnt + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // State, count and level registers.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      state <= cdv_pkg::CDV_HOLD;
      cnt   <= 4'h0;
      lvl   <= 1'b0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      lvl   <= next_lvl;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Output routing.
  // Direct routing picks a raw source; the undefined select pair falls back to
  // the divider so the pair always carries a defined clock.
  logic divider_out;
  logic forced;
  logic pair_lvl;

  // Forcing acts only while sync is asserted on a channel that ignores it.
  assign forced      = nosync && sync_asserted;
  assign divider_out = ch_bypass ? chan_in_lvl :
                       forced    ? force_high  : lvl;
  assign pair_lvl    = !direct                       ? divider_out :
                       (src_pair == cdv_pkg::ROUTE_VCO) ? vco_lvl :
                       (src_pair == cdv_pkg::ROUTE_EXT) ? ext_lvl :
                       divider_out;

  // Data outputs are registered so the pair never glitches on a mux change.
  // Output b is built from the same level so the pair stays exactly complementary.
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pair_c_output_a <= 1'b0;
      pair_c_output_b <= 1'b1;
      duty_correct_on <= 1'b1;
      divider_powered <= 1'b1;
    end else begin
      pair_c_output_a <= pair_lvl;
      pair_c_output_b <= !pair_lvl;
      duty_correct_on <= !act_regs.route[cdv_pkg::DCC_BIT];
      divider_powered <= !ch_bypass;
    end
  end

  // Live status: output level, divider level, state, sync and power flags.
  // The status word is read-only; writes to its index are acked and dropped.
  assign status_byte = {1'b0, clk_pd, sync_asserted, state == cdv_pkg::CDV_RUN,
                        state == cdv_pkg::CDV_DELAY, lvl, pair_c_output_b, pair_c_output_a};

endmodule
`default_nettype wire

// [test/cdv_checker.sv]
// Checker for the pair-C divider block: bus handshake and output pair relations.
// Assumes it is bound to cdv_top and sees nothing but that module's ports.
`default_nettype none
module cdv_checker (
  // Clock and reset.
  input wire logic        clock,
  input wire logic        reset,
  // Wishbone slave.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [11:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Output pair and status.
  input wire logic        pair_c_output_a,
  input wire logic        pair_c_output_b,
  input wire logic        duty_correct_on,
  input wire logic        divider_powered
);
  timeunit 1ns;
  timeprecision 1ns;
  wire logic [9:0] idx;
  wire logic       mapped;
  wire logic       upd_take;
  // Address decode; an update write is the only event that may move active settings.
  assign idx = wb_adr_i[11:2];
  assign mapped = idx inside {cdv_pkg::IDX_TIMING, cdv_pkg::IDX_CONTROL, cdv_pkg::IDX_ROUTE,
                  cdv_pkg::IDX_VCO_DIV, cdv_pkg::IDX_CLK_IN, cdv_pkg::IDX_UPDATE,
                  cdv_pkg::IDX_STATUS};
  assign upd_take = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
                    && wb_dat_i[0] && idx == cdv_pkg::IDX_UPDATE;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_take;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_read_upd;
    s_take ##0 (!wb_we_i && idx == cdv_pkg::IDX_UPDATE);
  endsequence
  sequence s_read_hole;
    s_take ##0 (!wb_we_i && !mapped);
  endsequence
  property p_ack_next;
    s_take |=> wb_ack_o;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o;
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_upper_zero;
    wb_ack_o |-> wb_dat_o[31:8] == 24'h0000_00;
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper read bits not zero");
  property p_upd_zero;
    s_read_upd |=> wb_dat_o == 32'h0000_0000;
  endproperty
  a_upd_zero: assert property (p_upd_zero) else $error("update bit not self-clearing");
  property p_hole_zero;
    s_read_hole |=> wb_ack_o && wb_dat_o == 32'h0000_0000;
  endproperty
  a_hole_zero: assert property (p_hole_zero) else $error("unmapped read not zero");
  property p_pair;
    pair_c_output_b == !pair_c_output_a;
  endproperty
  a_pair: assert property (p_pair) else $error("pair outputs not complementary");
  property p_dcc_hold;
    $changed(duty_correct_on) |-> $past(upd_take) || $past(upd_take, 2) || $past(upd_take, 3);
  endproperty
  a_dcc_hold: assert property (p_dcc_hold) else $error("duty flag moved without update");
  property p_pwr_hold;
    $changed(divider_powered) |-> $past(upd_take) || $past(upd_take, 2) || $past(upd_take, 3);
  endproperty
  a_pwr_hold: assert property (p_pwr_hold) else $error("power flag moved without update");
endmodule
`default_nettype wire

// [test/cdv_pair_sink.sv]
// Far-side model: a converter clock input that times each level of the output pair.
// Assumes the pair is registered on clock; lengths are counted in clock cycles.
`default_nettype none
module cdv_pair_sink (
  // Clock and pair output a.
  input  wire logic        clock,
  input  wire logic        out_a,
  // Measurements.
  output logic      [15:0] high_len,
  output logic      [15:0] low_len,
  output logic      [15:0] edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run;
  logic        last;
  // Latch the finished run on every level change; a static output leaves edges still.
  initial begin
    {run, last, high_len, low_len, edges} = '0;
  end
  always @(posedge clock) begin
    if (out_a !== last) begin
      if (last) high_len <= run;
      else low_len <= run;
      edges <= edges + 16'h0001;
      run <= 16'h0001;
    end else begin
      run <= run + 16'h0001;
    end
    last <= out_a;
  end
endmodule
`default_nettype wire

// [test/test_cdv_top.sv]
// Testbench for cdv_top: Wishbone register access and output pair timing.
// Assumes slow source pins made here and the pair sink model on the outputs.
`default_nettype none
module test_cdv_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic        vco_clk_pin, ext_clk_pin, sync_n_pin, out_a, out_b, dcc_on, div_pwr;
  logic [11:0] wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [15:0] high_len, low_len, edges, e0;
  int          errors, tests_run, ticks;
  cdv_top i_dut (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .vco_clk_pin(vco_clk_pin),
    .ext_clk_pin(ext_clk_pin), .sync_n_pin(sync_n_pin), .pair_c_output_a(out_a),
    .pair_c_output_b(out_b), .duty_correct_on(dcc_on), .divider_powered(div_pwr));
  cdv_pair_sink i_sink (.clock(clock), .out_a(out_a), .high_len(high_len),
    .low_len(low_len), .edges(edges));
  ////////////////////////////////////////////////////////////////////////////////
  // Clock at 20 MHz; the external source has period 8 cycles, the VCO source 6.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) begin
    ticks <= ticks + 1;
    ext_clk_pin <= (ticks % 8) < 4;
    vco_clk_pin <= (ticks % 6) < 3;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic cycle; held until ack is sampled, or given up as a mismatch after 50 cycles.
  task automatic wb(input logic [9:0] idx, input logic we, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hf;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= {24'h0000_00, wd};
    do begin
      @(posedge clock);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (n >= 50) chk(32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
    wb(idx, 1'b0, 8'h00);
    chk(rd, {24'h0000_00, exp});
  endtask
  // Writes land in buffers; the final update makes them all active at once.
  task automatic cfg(input logic [7:0] t, c, r, v, k);
    wb(cdv_pkg::IDX_TIMING, 1'b1, t);
    wb(cdv_pkg::IDX_CONTROL, 1'b1, c);
    wb(cdv_pkg::IDX_ROUTE, 1'b1, r);
    wb(cdv_pkg::IDX_VCO_DIV, 1'b1, v);
    wb(cdv_pkg::IDX_CLK_IN, 1'b1, k);
    wb(cdv_pkg::IDX_UPDATE, 1'b1, 8'h01);
  endtask
  task automatic run_chk(input int hi, input int lo);
    repeat (4 * (hi + lo) + 60) @(posedge clock);
    chk({16'h0000, high_len}, 32'(hi));
    chk({16'h0000, low_len}, 32'(lo));
  endtask
  task automatic still;
    repeat (120) @(posedge clock);
    e0 = edges;
    repeat (300) @(posedge clock);
    chk({16'h0000, edges}, {16'h0000, e0});
  endtask
  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // A hung handshake is already given up by wb after 50 cycles; cap the whole run in case anything else hangs.
  initial begin
    repeat (60000) @(posedge clock);
    errors++;
    give_verdict;
  end
  initial begin
    {reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {ticks, errors, tests_run, vco_clk_pin, ext_clk_pin} = '0;
    reset = 1'b1;
    sync_n_pin = 1'b1;
    wb_sel_i = 4'hf;
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    rd_chk(cdv_pkg::IDX_TIMING, 8'h00);
    rd_chk(cdv_pkg::IDX_CONTROL, 8'h00);
    rd_chk(cdv_pkg::IDX_ROUTE, 8'h00);
    rd_chk(cdv_pkg::IDX_VCO_DIV, 8'h02);
    rd_chk(cdv_pkg::IDX_CLK_IN, 8'h00);
    rd_chk(10'h100, 8'h00);
    chk({31'h0, dcc_on}, 32'h0000_0001);
    wb(cdv_pkg::IDX_TIMING, 1'b1, 8'h21);
    wb(cdv_pkg::IDX_CLK_IN, 1'b1, 8'h01);
    rd_chk(cdv_pkg::IDX_TIMING, 8'h21);
    run_chk(32, 32);
    wb(cdv_pkg::IDX_UPDATE, 1'b1, 8'h01);
    rd_chk(cdv_pkg::IDX_UPDATE, 8'h00);
    run_chk(16, 24);
    for (int v = 0; v < 8; v++) begin
      cfg(8'h00, 8'h00, 8'h00, 8'(v), 8'h00);
      if (v < 5) run_chk(8 * (v + 2), 8 * (v + 2));
      else still;
    end
    cfg(8'h00, 8'h00, 8'h00, 8'h02, 8'h10);
    still;
    cfg(8'h00, 8'h00, 8'h00, 8'h02, 8'h04);
    still;
    cfg(8'h00, 8'h00, 8'h00, 8'h02, 8'h08);
    run_chk(32, 32);
    cfg(8'h00, 8'h00, 8'h02, 8'h02, 8'h0a);
    still;
    cfg(8'h00, 8'h80, 8'h00, 8'h02, 8'h01);
    run_chk(4, 4);
    chk({31'h0, div_pwr}, 32'h0000_0000);
    cfg(8'h00, 8'h00, 8'h02, 8'h02, 8'h00);
    run_chk(4, 4);
    chk({31'h0, div_pwr}, 32'h0000_0001);
    cfg(8'h00, 8'h00, 8'h02, 8'h02, 8'h02);
    run_chk(3, 3);
    cfg(8'h00, 8'h00, 8'h03, 8'h02, 8'h01);
    run_chk(8, 8);
    chk({31'h0, dcc_on}, 32'h0000_0000);
    cfg(8'h00, 8'h00, 8'h00, 8'h00, 8'h02);
    run_chk(12, 12);
    cfg(8'h00, 8'h00, 8'h00, 8'h02, 8'h03);
    run_chk(24, 24);
    sync_n_pin <= 1'b0;
    cfg(8'hff, 8'h00, 8'h00, 8'h02, 8'h01);
    still;
    rd_chk(cdv_pkg::IDX_STATUS, 8'h22);
    for (int s = 0; s < 2; s++) begin
      cfg(8'hff, s ? 8'h10 : 8'h00, 8'h00, 8'h02, 8'h01);
      sync_n_pin <= 1'b1;
      repeat (12) @(posedge clock);
      chk({31'h0, out_a}, 32'(s));
      sync_n_pin <= 1'b0;
    end
    // A phase offset of three input edges delays the first rise past 20 cycles.
    for (int p = 0; p < 2; p++) begin
      cfg(8'h0f, p ? 8'h03 : 8'h00, 8'h00, 8'h02, 8'h01);
      sync_n_pin <= 1'b1;
      repeat (20) @(posedge clock);
      chk({31'h0, out_a}, 32'(p == 0));
      repeat (40) @(posedge clock);
      chk({31'h0, out_a}, 32'h0000_0001);
      sync_n_pin <= 1'b0;
    end
    cfg(8'h00, 8'h60, 8'h00, 8'h02, 8'h01);
    repeat (20) @(posedge clock);
    chk({31'h0, out_a}, 32'h0000_0001);
    chk({31'h0, out_b}, 32'h0000_0000);
    cfg(8'h00, 8'h40, 8'h00, 8'h02, 8'h01);
    repeat (20) @(posedge clock);
    chk({31'h0, out_a}, 32'h0000_0000);
    give_verdict;
  end
endmodule
bind cdv_top cdv_checker i_chk (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .pair_c_output_a(pair_c_output_a), .pair_c_output_b(pair_c_output_b),
  .duty_correct_on(duty_correct_on), .divider_powered(divider_powered));
`default_nettype wire
